// ### pkg/ccp_pwm_pkg.sv
// Purpose: shared constants and carrier types of the capture/compare pwm block
// Assumes: 8-bit register port, one system clock (oscillator clock)
// Notes:   timer a/b/c are the three selectable auto-reload time bases
package ccp_pwm_pkg;

  // register offsets
  localparam logic [3:0] ADDR_DUTY_LOW   = 4'h0;
  localparam logic [3:0] ADDR_DUTY_HIGH  = 4'h1;
  localparam logic [3:0] ADDR_UNIT_CTRL  = 4'h2;
  localparam logic [3:0] ADDR_TB_SELECT  = 4'h3;
  localparam logic [3:0] ADDR_PERIOD_A   = 4'h4; // period_reg_a..c follow
  localparam logic [3:0] ADDR_TCTRL_A    = 4'h7; // timer control a..c follow
  localparam logic [3:0] ADDR_COUNT_A    = 4'hA; // timer counts a..c, ro

  // field positions
  localparam int UNIT_EN_BIT    = 0; // unit_control_reg: pwm mode enable
  localparam int ALIGN_SEL_BIT  = 4; // unit_control_reg: duty_align_sel
  localparam int TMR_ON_BIT     = 2; // timer control: timer runs
  localparam int PRESC_LSB      = 0; // timer control: prescale code [1:0]
  localparam int POSTSC_LSB     = 4; // timer control: postscale [7:4]

  // reset values
  localparam logic [7:0] RST_REG8    = 8'h00;
  localparam logic [7:0] RST_PERIOD  = 8'hFF;
  localparam logic [9:0] RST_LATCH   = 10'h000;

  // timing: one timer increment cycle is four oscillator clocks
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          PHASES_PER_INC = 4;
  localparam logic [1:0]  PHASE_LAST     = 2'(PHASES_PER_INC - 1);
  localparam int          NUM_TIMERS     = 3;

  // prescale codes: 1:1, 1:4, 1:16, 1:64
  typedef enum logic [1:0] {
    PRESC_1, PRESC_4, PRESC_16, PRESC_64
  } presc_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0]                  duty_low;
    logic [7:0]                  duty_high;
    logic [7:0]                  unit_ctrl;
    logic [7:0]                  tb_select;
    logic [NUM_TIMERS-1:0][7:0]  period;
    logic [NUM_TIMERS-1:0][7:0]  tctrl;
    logic [NUM_TIMERS-1:0][7:0]  count;
    logic [NUM_TIMERS-1:0][5:0]  presc_cnt;
    logic [1:0]                  phase;
    logic [9:0]                  duty_latch;
    logic                        pin;
    logic                        internal;
    logic [7:0]                  rdata;
  } state_t;

endpackage

// ### rtl/ccp_pwm.sv
// Purpose: pulse-width generation mode of a capture/compare unit with its
//          three shared 8-bit auto-reload period timers
// Assumes: i_ref_clk is the oscillator clock; inputs synchronous to it
// Notes:   read data appear one cycle after the read strobe and only then
//
// Functional notes
// - unit picks timer a, b or c through shared timebase_select_reg.
// - period is (period value + 1) x 4 clocks x prescale factor.
// - count equal to period value clears timer at next increment.
// - new period drives pin high unless buffered duty is zero.
// - each period boundary with the unit enabled copies duty register pair into 10-bit latch.
// - timer postscaler never affects waveform period or frequency.
// - align bit clear: duty msbs in high bits 1..0, rest low.
// - align bit set: upper eight in high, lsbs in low bits 7..6.
// - duty writes any time, take effect only after current period.
// - time base is count plus phase bits, or two prescaler bits.
// - time base equal to latched duty drives pin low.
// - duty beyond period leaves the pin at its present level.
// - reset returns all block registers to reset values.
// - waveform also offered as internal signal for on-chip consumers.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ccp_pwm
  import ccp_pwm_pkg::*;
(
  input  wire logic     i_ref_clk,
  input  wire logic     i_srst,
  input  wire bus_req_t i_bus,
  output logic [7:0]    o_rdata,
  output logic          o_pulse_out_pin,
  output logic          o_pwm_internal
);

  state_t st_q;
  state_t st_d;

  // terminal prescaler count for a prescale code
  function automatic logic [5:0] presc_max(input logic [1:0] code);
    case (presc_t'(code))
      PRESC_1:  presc_max = 6'h00;
      PRESC_4:  presc_max = 6'h03;
      PRESC_16: presc_max = 6'h0F;
      default:  presc_max = 6'h3F;
    endcase
  endfunction

  // two fine bits appended below the timer count
  function automatic logic [1:0] fine_bits(input logic [1:0] code,
                                           input logic [1:0] phase,
                                           input logic [5:0] pcnt);
    case (presc_t'(code))
      PRESC_1:  fine_bits = phase;
      PRESC_4:  fine_bits = pcnt[1:0];
      PRESC_16: fine_bits = pcnt[3:2];
      default:  fine_bits = pcnt[5:4];
    endcase
  endfunction

  logic [NUM_TIMERS-1:0] inc_tick;  // timer increments this cycle
  logic [NUM_TIMERS-1:0] wrap_tick; // timer wraps to zero this cycle

  // per-timer increment and period-match decode
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
      assign inc_tick[g] = st_q.tctrl[g][TMR_ON_BIT]
                         && (st_q.phase == PHASE_LAST)
                         && (st_q.presc_cnt[g]
                             == presc_max(st_q.tctrl[g][PRESC_LSB +: 2]));
      assign wrap_tick[g] = inc_tick[g]
                          && (st_q.count[g] == st_q.period[g]);
    end
  endgenerate

  logic [1:0] sel;
  logic       boundary;
  logic [9:0] time_base;  // time base as it stands after this edge
  logic [9:0] duty_value;
  logic       unit_en;

  // selected time base and the duty value as software laid it out
  always_comb begin
    sel = (st_q.tb_select[1:0] == 2'h3) ? 2'h0 : st_q.tb_select[1:0];
    boundary  = wrap_tick[sel];
    if (st_q.unit_ctrl[ALIGN_SEL_BIT]) begin
      duty_value = {st_q.duty_high, st_q.duty_low[7:6]};
    end else begin
      duty_value = {st_q.duty_high[1:0], st_q.duty_low};
    end
    unit_en = st_q.unit_ctrl[UNIT_EN_BIT];
  end

  // next-state logic: registers, timers, duty latch, pin
  always_comb begin
    st_d = st_q;
    st_d.phase = st_q.phase + 2'h1;
    // prescalers and timers; postscale field is stored only
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (st_q.tctrl[i][TMR_ON_BIT] && st_q.phase == PHASE_LAST) begin
        if (inc_tick[i]) begin
          st_d.presc_cnt[i] = 6'h00;
          st_d.count[i] = wrap_tick[i] ? 8'h00 : st_q.count[i] + 8'h01;
        end else begin
          st_d.presc_cnt[i] = st_q.presc_cnt[i] + 6'h01;
        end
      end
    end
    // compare the time base the timers show after this edge, so the
    // registered pin falls on the very edge at which the match begins
    time_base = {st_d.count[sel],
                 fine_bits(st_d.tctrl[sel][PRESC_LSB +: 2],
                           st_d.phase, st_d.presc_cnt[sel])};
    // waveform: boundary set has priority over the compare clear
    if (!unit_en) begin
      st_d.pin = 1'b0;
    end else if (boundary) begin
      st_d.duty_latch = duty_value;
      st_d.pin = (duty_value != 10'h000);
    end else if (time_base == st_q.duty_latch) begin
      st_d.pin = 1'b0;
    end // otherwise the level holds
    st_d.internal = st_d.pin;
    // register writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        ADDR_DUTY_LOW:  st_d.duty_low  = i_bus.wdata;
        ADDR_DUTY_HIGH: st_d.duty_high = i_bus.wdata;
        ADDR_UNIT_CTRL: st_d.unit_ctrl = i_bus.wdata;
        ADDR_TB_SELECT: st_d.tb_select = i_bus.wdata;
        ADDR_PERIOD_A:  st_d.period[0] = i_bus.wdata;
        4'h5:           st_d.period[1] = i_bus.wdata;
        4'h6:           st_d.period[2] = i_bus.wdata;
        ADDR_TCTRL_A:   st_d.tctrl[0]  = i_bus.wdata;
        4'h8:           st_d.tctrl[1]  = i_bus.wdata;
        4'h9:           st_d.tctrl[2]  = i_bus.wdata;
        default: ;
      endcase
    end
    // register reads, answered next cycle, zero otherwise
    st_d.rdata = 8'h00;
    if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_DUTY_LOW:  st_d.rdata = st_q.duty_low;
        ADDR_DUTY_HIGH: st_d.rdata = st_q.duty_high;
        ADDR_UNIT_CTRL: st_d.rdata = st_q.unit_ctrl;
        ADDR_TB_SELECT: st_d.rdata = st_q.tb_select;
        ADDR_PERIOD_A:  st_d.rdata = st_q.period[0];
        4'h5:           st_d.rdata = st_q.period[1];
        4'h6:           st_d.rdata = st_q.period[2];
        ADDR_TCTRL_A:   st_d.rdata = st_q.tctrl[0];
        4'h8:           st_d.rdata = st_q.tctrl[1];
        4'h9:           st_d.rdata = st_q.tctrl[2];
        ADDR_COUNT_A:   st_d.rdata = st_q.count[0];
        4'hB:           st_d.rdata = st_q.count[1];
        4'hC:           st_d.rdata = st_q.count[2];
        default:        st_d.rdata = 8'h00;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_q.duty_low   <= RST_REG8;
      st_q.duty_high  <= RST_REG8;
      st_q.unit_ctrl  <= RST_REG8;
      st_q.tb_select  <= RST_REG8;
      st_q.period     <= {NUM_TIMERS{RST_PERIOD}};
      st_q.tctrl      <= {NUM_TIMERS{RST_REG8}};
      st_q.count      <= {NUM_TIMERS{RST_REG8}};
      st_q.presc_cnt  <= '0;
      st_q.phase      <= 2'h0;
      st_q.duty_latch <= RST_LATCH;
      st_q.pin        <= 1'b0;
      st_q.internal   <= 1'b0;
      st_q.rdata      <= RST_REG8;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign o_rdata         = st_q.rdata;
  assign o_pulse_out_pin = st_q.pin;
  assign o_pwm_internal  = st_q.internal;

  // helper: cycles since the last boundary, valid while config is steady
  logic [17:0] gap_q;
  logic        gap_ok_q;
  logic [17:0] expect_len;
  always_comb begin
    expect_len = 18'({10'h000, st_q.period[sel]} + 18'h1)
               * 18'(PHASES_PER_INC)
               * 18'({12'h000, presc_max(st_q.tctrl[sel][1:0])} + 18'h1);
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      gap_q    <= 18'h0;
      gap_ok_q <= 1'b0;
    end else begin
      gap_q    <= boundary ? 18'h1 : gap_q + 18'h1;
      if (i_bus.wr && i_bus.addr >= ADDR_TB_SELECT) begin
        gap_ok_q <= 1'b0;
      end else if (boundary) begin
        gap_ok_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  a_period_length: assert property (boundary && gap_ok_q
    |-> gap_q == expect_len) else $error("period length wrong");
  a_timer_clear: assert property (boundary && !(i_bus.wr)
    |=> st_q.count[$past(sel)] == 8'h00) else $error("timer not cleared");
  a_pin_set: assert property (unit_en && boundary && duty_value != 10'h0
    |=> o_pulse_out_pin && o_pwm_internal) else $error("pin not set");
  a_zero_duty_low: assert property (unit_en && boundary
    && duty_value == 10'h0 |=> !o_pulse_out_pin) else $error("zero duty set");
  a_latch_right: assert property (unit_en && boundary
    && !st_q.unit_ctrl[ALIGN_SEL_BIT]
    |=> st_q.duty_latch == {$past(st_q.duty_high[1:0]),
                            $past(st_q.duty_low)})
    else $error("right aligned latch wrong");
  a_latch_left: assert property (unit_en && boundary
    && st_q.unit_ctrl[ALIGN_SEL_BIT]
    |=> st_q.duty_latch == {$past(st_q.duty_high),
                            $past(st_q.duty_low[7:6])})
    else $error("left aligned latch wrong");
  a_latch_holds: assert property (!boundary
    |=> $stable(st_q.duty_latch)) else $error("latch changed mid period");
  a_match_clears: assert property (unit_en && !boundary
    && time_base == st_q.duty_latch |=> !o_pulse_out_pin)
    else $error("match did not clear pin");
  a_overrun_hold: assert property (unit_en && !boundary
    && time_base != st_q.duty_latch |=> $stable(o_pulse_out_pin))
    else $error("pin changed without cause");
  a_reset_state: assert property ($past(i_srst) |->
    st_q.duty_latch == 10'h0 && !o_pulse_out_pin)
    else $error("reset state wrong");
  a_internal_copy: assert property (o_pwm_internal
    == o_pulse_out_pin)
    else $error("internal copy wrong");

endmodule
`default_nettype wire

// ### test/pulse_meter.sv
// Purpose: on-chip consumer model that measures the internal waveform
// Assumes: one clock; waveform registered in the same domain
// Notes:   reports period and high time at each rising edge
`timescale 1ns/1ps
`default_nettype none
module pulse_meter (
  input  wire logic   i_ref_clk,
  input  wire logic   i_sig,
  output logic [15:0] o_period,
  output logic [15:0] o_high,
  output logic        o_valid
);
  logic        prev_q;
  logic [15:0] per_q;
  logic [15:0] hi_q;
  // count all and high cycles, report at each rise of the consumer input
  always_ff @(posedge i_ref_clk) begin
    prev_q  <= i_sig;
    o_valid <= i_sig && !prev_q;
    if (i_sig && !prev_q) begin
      o_period <= per_q;
      o_high   <= hi_q;
      per_q    <= 16'h0001;
      hi_q     <= 16'h0001;
    end else begin
      per_q <= per_q + 16'h0001;
      hi_q  <= hi_q + {15'h0000, i_sig};
    end
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench of the pwm mode block
// Assumes: bench drives the register port by nba after rising edges
// Notes:   each case starts from a fresh reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccp_pwm_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_srst = 1'b1;
  bus_req_t    i_bus = '0;
  logic [7:0]  o_rdata;
  logic        pin;
  logic        internal;
  logic [15:0] m_per;
  logic [15:0] m_hi;
  logic        m_valid;
  int          failures = 0;
  int          comparisons = 0;
  int          seed = 54137;
  int          tests = 0;
  logic [7:0]  rq[$];
  logic [31:0] wq[$];
  logic        pend = 1'b0;
  always #4 i_ref_clk = ~i_ref_clk;
  ccp_pwm ccp_pwm_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_bus(i_bus),
    .o_rdata(o_rdata), .o_pulse_out_pin(pin), .o_pwm_internal(internal));
  pulse_meter pulse_meter_i (.i_ref_clk(i_ref_clk), .i_sig(internal),
    .o_period(m_per), .o_high(m_hi), .o_valid(m_valid));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Counts: %0d compared, %0d failed", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    rq.push_back(exp);
    @(posedge i_ref_clk);
  endtask
  task automatic idle(input int n);
    i_bus <= '0;
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wait_meas(input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      while (!m_valid) @(posedge i_ref_clk);
    end
  endtask
  // write a duty value in the chosen alignment
  task automatic put_duty(input logic [9:0] d, input logic al);
    wr(ADDR_DUTY_LOW, al ? {d[1:0], 6'h00} : d[7:0]);
    wr(ADDR_DUTY_HIGH, al ? d[9:2] : {6'h00, d[9:8]});
  endtask
  // one waveform case on a randomly chosen timer
  task automatic run_case(input logic [1:0] pc, input logic [7:0] per,
    input logic [9:0] d, input logic al, input logic [9:0] nd);
    logic [1:0] k;
    int         f;
    int         p;
    logic       bad;
    k = 2'($unsigned($random(seed)) % 3);
    f = 1 << (2 * pc);
    p = (per + 1) * 4 * f;
    bad = 1'b0;
    i_srst <= 1'b1;
    idle(2);
    i_srst <= 1'b0;
    idle(1);
    wr(ADDR_TB_SELECT, {6'h00, k});
    wr(ADDR_PERIOD_A + {2'b00, k}, per);
    put_duty(d, al);
    wr(ADDR_UNIT_CTRL, {3'h0, al, 3'h0, 1'b1});
    // random postscale must leave the period alone
    wr(ADDR_TCTRL_A + {2'b00, k}, {4'($random(seed)), 2'b01, pc});
    idle(1);
    if (d == 10'h000 || d >= 10'((per + 1) * 4)) begin
      repeat (3 * p) @(posedge i_ref_clk);
      repeat (2 * p) begin
        @(negedge i_ref_clk);
        if (pin !== (d != 10'h000) || internal !== pin) bad = 1'b1;
      end
      check({31'h0, bad}, 32'h0);
    end else begin
      wait_meas(3);
      wq.push_back({16'(d * f), 16'(p)});
      if (nd != 10'h000) begin
        put_duty(nd, al);
        idle(0);
        wq.push_back({16'(nd * f), 16'(p)});
        wait_meas(1);
      end
      wait_meas(1);
    end
    tests++;
    $display("test %0d done", tests);
  endtask
  // read data stand only in the cycle after the strobe
  always @(negedge i_ref_clk) begin
    if (pend) check({24'h0, o_rdata}, {24'h0, rq.pop_front()});
    pend = i_bus.rd;
    if (m_valid && wq.size() > 0) check({m_hi, m_per}, wq.pop_front());
  end
  initial begin
    #200000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    for (int i = 0; i < 3; i++) rd(ADDR_PERIOD_A + 4'(i), RST_PERIOD);
    rd(ADDR_DUTY_LOW, RST_REG8);
    wr(ADDR_COUNT_A, 8'h55);
    wr(4'hE, 8'hA5);
    wr(ADDR_DUTY_LOW, 8'h5A);
    rd(ADDR_COUNT_A, 8'h00);
    rd(4'hE, 8'h00);
    rd(ADDR_DUTY_LOW, 8'h5A);
    idle(2);
    $display("register test done");
    run_case(2'd0, 8'h00, 10'h002, 1'b0, 10'h000);
    run_case(2'd1, 8'h02, 10'h005, 1'b1, 10'h000);
    run_case(2'd2, 8'h01, 10'h007, 1'b0, 10'h000);
    run_case(2'd3, 8'h00, 10'h003, 1'b1, 10'h000);
    run_case(2'd0, 8'h13, 10'(1 + $unsigned($random(seed)) % 79), 1'b0,
      10'h00A);
    run_case(2'd0, 8'h03, 10'h000, 1'b0, 10'h000);
    run_case(2'd1, 8'h01, 10'h3FF, 1'b1, 10'h000);
    idle(2);
    check(32'(wq.size() + rq.size()), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
